// ---- core/amx_mux_control.sv ----
// Top of the comparator input mux control with its AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module amx_mux_control (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Comparator raw output from analog side
   input  wire logic               comparator_raw,
   // Switch enables to analog side
   output var amx_pkg::amx_switch_t switches,
   // Comparator result after phase correction
   output logic                    comparator_out
);

   // Register contents
   logic [7:0] channel_pin_selects;  // analog_mux_control_one
   logic       sample_track_select;  // Hold bit
   logic       divide_track_select;  // Divide bit
   logic       comparator_swap;      // Internal inversion
   logic       supply_ref_select;    // Supply onto bus
   logic       bias_ref_select;      // Bias onto bus
   logic       comparator_flag;      // Sticky rising result flag

   // Write channel capture
   logic       aw_held;              // Address taken, waiting data
   logic       w_held;               // Data taken, waiting address
   logic [7:0] aw_addr;              // Captured write address
   logic [31:0] w_data;              // Captured write data
   logic [3:0] w_strb;               // Captured byte enables
   logic       wr_go;                // Both halves present this cycle
   logic [7:0] wr_addr;              // Effective write address
   logic [31:0] wr_data;             // Effective write data
   logic [3:0] wr_strb;              // Effective byte enables
   logic       wr_hit;               // Write address is mapped
   logic       clear_pulse;          // Flag clear requested this cycle

   // Comparator path with three-stage synchroniser
   logic [2:0] cmp_sync;             // Raw output sampling chain
   logic       cmp_state;            // Filtered, phase-corrected level
   logic       cmp_prev;             // Previous filtered level

   // Read side
   logic [31:0] next_rdata;          // Data for the addressed register
   logic        rd_hit;              // Read address is mapped

   // Channels accept only when no response is pending
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // Merge held and live halves of a write
   always_comb begin
      wr_addr = aw_held ? aw_addr : s_axi_awaddr;
      wr_data = w_held ? w_data : s_axi_wdata;
      wr_strb = w_held ? w_strb : s_axi_wstrb;
      wr_go   = (aw_held | (s_axi_awvalid & s_axi_awready))
                & (w_held | (s_axi_wvalid & s_axi_wready));
      wr_hit  = (wr_addr == amx_pkg::CTRL_OFFSET)
                | (wr_addr == amx_pkg::MODE_OFFSET)
                | (wr_addr == amx_pkg::FLAG_OFFSET);
      clear_pulse = wr_go & (wr_addr == amx_pkg::FLAG_OFFSET)
                    & wr_strb[0]
                    & wr_data[amx_pkg::FLAG_CLEAR_BIT];
   end

   // Hold whichever write half arrives first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else if (wr_go) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // Write response, unmapped addresses answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= amx_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? amx_pkg::RESP_OKAY
                                : amx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Channel select register; hold bits live apart so software can
   // freeze the sample before touching the channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_pin_selects <= amx_pkg::CTRL_RESET;
      end else if (wr_go && wr_addr == amx_pkg::CTRL_OFFSET
                   && wr_strb[0]) begin
         channel_pin_selects <= wr_data[7:0];
      end
   end

   // Mode register: hold, divide, swap and reference selects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_track_select <= amx_pkg::MODE_RESET[amx_pkg::MODE_HOLD_BIT];
         divide_track_select <= amx_pkg::MODE_RESET[amx_pkg::MODE_DIV_BIT];
         comparator_swap     <= amx_pkg::MODE_RESET[amx_pkg::MODE_SWAP_BIT];
         supply_ref_select   <=
            amx_pkg::MODE_RESET[amx_pkg::MODE_SUPPLY_BIT];
         bias_ref_select     <= amx_pkg::MODE_RESET[amx_pkg::MODE_BIAS_BIT];
      end else if (wr_go && wr_addr == amx_pkg::MODE_OFFSET
                   && wr_strb[0]) begin
         // Stored as written; an illegal pair is decoded safely
         sample_track_select <= wr_data[amx_pkg::MODE_HOLD_BIT];
         divide_track_select <= wr_data[amx_pkg::MODE_DIV_BIT];
         comparator_swap     <= wr_data[amx_pkg::MODE_SWAP_BIT];
         supply_ref_select   <= wr_data[amx_pkg::MODE_SUPPLY_BIT];
         bias_ref_select     <= wr_data[amx_pkg::MODE_BIAS_BIT];
      end
   end

   // Comparator raw output enters through three flip-flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_sync <= 3'b000;
      end else begin
         cmp_sync <= {cmp_sync[1:0], comparator_raw};
      end
   end

   // Accept a change once stages two and three agree; undo the
   // internal inversion so the result keeps its phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_state <= 1'b0;
         cmp_prev  <= 1'b0;
      end else begin
         if (cmp_sync[1] == cmp_sync[2]) begin
            cmp_state <= cmp_sync[2] ^ comparator_swap;
         end
         cmp_prev <= cmp_state;
      end
   end

   // Sticky flag on a rising result; a swap can also raise it, which
   // is why software clears it after changing the swap bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         comparator_flag <= 1'b0;
      end else if (cmp_state & ~cmp_prev) begin
         comparator_flag <= 1'b1;  // Set wins over a same-cycle clear
      end else if (clear_pulse) begin
         comparator_flag <= 1'b0;
      end
   end

   // Read data selection
   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_hit     = 1'b1;
      unique case (s_axi_araddr)
         amx_pkg::CTRL_OFFSET: next_rdata[7:0] = channel_pin_selects;
         amx_pkg::MODE_OFFSET: begin
            next_rdata[amx_pkg::MODE_HOLD_BIT]   = sample_track_select;
            next_rdata[amx_pkg::MODE_DIV_BIT]    = divide_track_select;
            next_rdata[amx_pkg::MODE_SWAP_BIT]   = comparator_swap;
            next_rdata[amx_pkg::MODE_SUPPLY_BIT] = supply_ref_select;
            next_rdata[amx_pkg::MODE_BIAS_BIT]   = bias_ref_select;
         end
         amx_pkg::FLAG_OFFSET: begin
            // Clear bit always reads zero
            next_rdata[amx_pkg::FLAG_STATE_BIT] = comparator_flag;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read response registered one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= amx_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_hit ? amx_pkg::RESP_OKAY
                                : amx_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Result output follows the filtered level
   assign comparator_out = cmp_state;

   // Analog switch decoding
   amx_switch_decode u_decode (
      .channel_pin_selects (channel_pin_selects),
      .supply_ref_select   (supply_ref_select),
      .bias_ref_select     (bias_ref_select),
      .sample_track_select (sample_track_select),
      .divide_track_select (divide_track_select),
      .comparator_swap     (comparator_swap),
      .switches            (switches)
   );

endmodule : amx_mux_control

`default_nettype wire

// ---- core/amx_pkg.sv ----
// Package of register map, field layout and carrier types for the mux control
package amx_pkg;

   // Register byte offsets (control words of this block)
   localparam logic [7:0] CTRL_OFFSET  = 8'h00;  // analog_mux_control_one
   localparam logic [7:0] MODE_OFFSET  = 8'h04;  // reference, swap, hold bits
   localparam logic [7:0] FLAG_OFFSET  = 8'h08;  // comparator flag / clear

   // Field positions in the mode register
   localparam int MODE_HOLD_BIT   = 0;  // sample-track select
   localparam int MODE_DIV_BIT    = 1;  // divide_track_select
   localparam int MODE_SWAP_BIT   = 2;  // comparator_swap
   localparam int MODE_SUPPLY_BIT = 3;  // supply reference select
   localparam int MODE_BIAS_BIT   = 4;  // bias_ref_select

   // Field positions in the flag register
   localparam int FLAG_STATE_BIT = 0;  // comparator_flag, read only
   localparam int FLAG_CLEAR_BIT = 1;  // comparator_flag_clear, write one

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [4:0] MODE_RESET = 5'h01;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Comparator input source selection
   typedef enum logic [1:0] {
      AMX_SRC_HOLD   = 2'b00,  // Sample capacitor only on negative input
      AMX_SRC_DIV    = 2'b01,  // Halved bus to capacitor and input
      AMX_SRC_DIRECT = 2'b10,  // Bus direct to capacitor and input
      AMX_SRC_BAD    = 2'b11   // Illegal combination
   } amx_src_t;

   // Switch controls handed to the analog side
   typedef struct packed {
      logic [7:0] pin_close;      // Per-pin switch onto channel bus
      logic       supply_close;   // Supply onto channel bus
      logic       bias_close;     // Bias onto channel bus
      logic       ground_close;   // Ground onto channel bus
      logic       cap_to_bus;     // Sample cap joined to bus path
      logic       bus_to_neg;     // Bus path drives comparator negative input
      logic       halve_bus;      // Route bus through divider
      logic       swap_nodes;     // Exchange internal comparator nodes
   } amx_switch_t;

endpackage : amx_pkg

// ---- core/amx_switch_decode.sv ----
// Switch decoder turning control bits into analog switch enables
`timescale 1ns/1ps
`default_nettype none

module amx_switch_decode (
   // Control bits
   input  wire logic [7:0]         channel_pin_selects,
   input  wire logic               supply_ref_select,
   input  wire logic               bias_ref_select,
   input  wire logic               sample_track_select,
   input  wire logic               divide_track_select,
   input  wire logic               comparator_swap,
   // Switch enables
   output var amx_pkg::amx_switch_t switches
);

   logic            any_pin;  // Some channel pin selected
   amx_pkg::amx_src_t src;    // Decoded comparator source

   // Decode the source selection and bus connections
   always_comb begin
      any_pin = |channel_pin_selects;
      src = amx_pkg::amx_src_t'({sample_track_select, divide_track_select});
      switches.pin_close    = channel_pin_selects;
      // Supply only when no pin and no bias
      switches.supply_close = supply_ref_select & ~any_pin
                              & ~bias_ref_select;
      // Bias only when no pin and no supply
      switches.bias_close   = bias_ref_select & ~any_pin
                              & ~supply_ref_select;
      // Ground only when nothing else asked for
      switches.ground_close = ~any_pin & ~supply_ref_select
                              & ~bias_ref_select;
      switches.swap_nodes   = comparator_swap;
      unique case (src)
         amx_pkg::AMX_SRC_HOLD: begin
            // Cap isolated from bus, sits on negative input only
            switches.cap_to_bus = 1'b0;
            switches.bus_to_neg = 1'b0;
            switches.halve_bus  = 1'b0;
         end
         amx_pkg::AMX_SRC_DIV: begin
            switches.cap_to_bus = 1'b1;
            switches.bus_to_neg = 1'b1;
            switches.halve_bus  = 1'b1;
         end
         amx_pkg::AMX_SRC_DIRECT: begin
            switches.cap_to_bus = 1'b1;
            switches.bus_to_neg = 1'b1;
            switches.halve_bus  = 1'b0;
         end
         default: begin
            // Illegal pair: fall back to hold so nothing is disturbed
            switches.cap_to_bus = 1'b0;
            switches.bus_to_neg = 1'b0;
            switches.halve_bus  = 1'b0;
         end
      endcase
   end

endmodule : amx_switch_decode

`default_nettype wire

// ---- tb/amx_mux_control_assertions.sv ----
// Checker for the switch decode and comparator phase of the mux control
`timescale 1ns/1ps
`default_nettype none

module amx_mux_control_checker (
   // Clock and reset
   input wire logic                 aclk,
   input wire logic                 aresetn,
   // Comparator and switch side
   input wire logic                 comparator_raw,
   input wire amx_pkg::amx_switch_t switches,
   input wire logic                 comparator_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Reset leaves the bus grounded and the capacitor on the direct path
   property p_reset;
      $rose(aresetn) |-> switches.ground_close && switches.cap_to_bus
         && switches.bus_to_neg && !switches.halve_bus
         && switches.pin_close == 8'h00 && !switches.swap_nodes;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset switch state wrong");
   // Hold case isolates the capacitor from the bus
   property p_hold;
      !switches.bus_to_neg |-> !switches.cap_to_bus && !switches.halve_bus;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold case leaves capacitor on bus");
   property p_div;
      switches.halve_bus |-> switches.cap_to_bus && switches.bus_to_neg;
   endproperty
   a_div: assert property (p_div)
      else $error("halved bus not on capacitor and input");
   property p_direct;
      switches.cap_to_bus |-> switches.bus_to_neg;
   endproperty
   a_direct: assert property (p_direct)
      else $error("capacitor joined without negative input");
   // Each reference only alone on the bus
   property p_supply;
      switches.supply_close |-> switches.pin_close == 8'h00
         && !switches.bias_close && !switches.ground_close;
   endproperty
   a_supply: assert property (p_supply)
      else $error("supply closed with another source");
   property p_bias;
      switches.bias_close |-> switches.pin_close == 8'h00
         && !switches.supply_close && !switches.ground_close;
   endproperty
   a_bias: assert property (p_bias)
      else $error("bias closed with another source");
   property p_ground;
      switches.ground_close |-> switches.pin_close == 8'h00;
   endproperty
   a_ground: assert property (p_ground)
      else $error("ground closed with a pin");
   // Settled result keeps its phase whatever the swap state
   property p_swap;
      ($stable(comparator_raw) && $stable(switches.swap_nodes))[*6]
         |-> comparator_out == (comparator_raw ^ switches.swap_nodes);
   endproperty
   a_swap: assert property (p_swap)
      else $error("comparator result phase wrong");

   // Main scenarios
   c_supply: cover property (switches.supply_close);
   c_bias: cover property (switches.bias_close);
   c_halve: cover property (switches.halve_bus);
endmodule : amx_mux_control_checker

bind amx_mux_control amx_mux_control_checker chk_u (.*);

`default_nettype wire

// ---- tb/amx_mux_control_tb.sv ----
// Testbench for the comparator input mux control
`timescale 1ns/1ps
`default_nettype none

module amx_mux_control_tb;
   // Design signals, named as the ports
   logic                 aclk, aresetn, comparator_raw, comparator_out;
   logic [7:0]           s_axi_awaddr, s_axi_araddr;
   logic [31:0]          s_axi_wdata, s_axi_rdata;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                 s_axi_rready;
   amx_pkg::amx_switch_t switches;
   int                   fails, samples_checked;
   logic [1:0]           r;
   logic [31:0]          d;

   amx_mux_control dut_u (.*);

   // Free running clock
   always #5 aclk = ~aclk;

   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk

   // Write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      rs = s_axi_bresp;
      if (n >= 50) fails++;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      if (n >= 50) fails++;
   endtask : rd

   // Expected switch state worked out from pins and mode bits
   function automatic logic [31:0] ex(input logic [7:0] p,
                                      input logic [4:0] m);
      amx_pkg::amx_switch_t s;
      s.pin_close = p;
      s.supply_close = m[3] & ~|p & ~m[4];
      s.bias_close = m[4] & ~|p & ~m[3];
      s.ground_close = ~|{p, m[4:3]};
      s.cap_to_bus = m[0] ^ m[1];
      s.bus_to_neg = m[0] ^ m[1];
      s.halve_bus = m[1:0] == 2'b10;
      s.swap_nodes = m[2];
      return {17'h0_0000, s};
   endfunction : ex

   task automatic t_reset();
      chk("switches", ex(8'h00, 5'h01), {17'h0_0000, switches});
      rd(amx_pkg::CTRL_OFFSET, d, r);
      chk("ctrl", 32'h0000_0000, d);
      rd(amx_pkg::MODE_OFFSET, d, r);
      chk("mode", 32'h0000_0001, d);
      rd(amx_pkg::FLAG_OFFSET, d, r);
      chk("flag", 32'h0000_0000, d);
   endtask : t_reset

   // Mode cleared before the channel changes, then new mode
   task automatic t_cfg(input logic [7:0] p, input logic [4:0] m);
      wr(amx_pkg::MODE_OFFSET, 32'h0000_0000, r);
      wr(amx_pkg::CTRL_OFFSET, {24'h00_0000, p}, r);
      // Callers never pass hold and divide both set
      wr(amx_pkg::MODE_OFFSET, {27'h000_0000, m}, r);
      chk("bresp", 32'h0000_0000, {30'h0, r});
      chk("switches", ex(p, m), {17'h0_0000, switches});
      rd(amx_pkg::CTRL_OFFSET, d, r);
      chk("ctrl", {24'h00_0000, p}, d);
      rd(amx_pkg::MODE_OFFSET, d, r);
      chk("mode", {27'h000_0000, m}, d);
   endtask : t_cfg

   task automatic t_unmapped();
      wr(8'h0C, 32'h0000_00FF, r);
      chk("bresp", 32'h0000_0002, {30'h0, r});
      rd(8'h0C, d, r);
      chk("rresp", 32'h0000_0002, {30'h0, r});
      chk("rdata", 32'h0000_0000, d);
   endtask : t_unmapped

   // Raw level in, settled result and flag out
   task automatic t_comp(input logic raw, input logic [4:0] m,
                         input logic e);
      wr(amx_pkg::MODE_OFFSET, {27'h000_0000, m}, r);
      comparator_raw <= raw;
      repeat (8) @(posedge aclk);
      chk("comparator_out", {31'h0, e}, {31'h0, comparator_out});
      rd(amx_pkg::FLAG_OFFSET, d, r);
      chk("flag", {31'h0, e}, d);
      wr(amx_pkg::FLAG_OFFSET, 32'h0000_0002, r);
      rd(amx_pkg::FLAG_OFFSET, d, r);
      chk("flag", 32'h0000_0000, d);
   endtask : t_comp

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   // Cut a hang short
   initial begin
      #100000;
      fails++;
      end_of_test();
   end

   // Main sequence
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      comparator_raw = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid} = '0;
      s_axi_arvalid = 1'b0;
      // Response ready held high so back-to-back calls never re-drive it
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_cfg(8'h00, 5'h00);
      t_cfg(8'h00, 5'h02);
      t_cfg(8'hA5, 5'h01);
      t_cfg(8'h00, 5'h08);
      t_cfg(8'h00, 5'h10);
      t_cfg(8'h00, 5'h18);
      t_cfg(8'h01, 5'h08);
      t_cfg(8'hFF, 5'h14);
      t_unmapped();
      t_comp(1'b1, 5'h01, 1'b1);
      t_comp(1'b0, 5'h05, 1'b1);
      t_comp(1'b1, 5'h05, 1'b0);
      end_of_test();
   end
endmodule : amx_mux_control_tb

`default_nettype wire
